// ---- shared/bgd_map.svh ----
// Purpose: Timing counts and input positions for the buck gate-drive sequencer
// Assumes: 200 MHz system clock
// Notes:   Times are kept in their own unit; cycle counts derive from them
`ifndef BGD_MAP_SVH
`define BGD_MAP_SVH

// ----------------------------------------------------------------------------
// Clock and conversion
// ----------------------------------------------------------------------------
`define BGD_CLK_MHZ          200
`define BGD_CYC_UP(ns)       ((((ns) * `BGD_CLK_MHZ) + 999) / 1000)
`define BGD_CYC_DN(ns)       (((ns) * `BGD_CLK_MHZ) / 1000)

// ----------------------------------------------------------------------------
// Switching cycle
// ----------------------------------------------------------------------------
`define BGD_FSW_KHZ          410
`define BGD_PERIOD_CYC       ((`BGD_CLK_MHZ * 1000) / `BGD_FSW_KHZ)
`define BGD_MIN_OFF_NS       200
`define BGD_MIN_OFF_CYC      `BGD_CYC_UP(`BGD_MIN_OFF_NS)
`define BGD_REASSERT_PERIODS 3

// ----------------------------------------------------------------------------
// Low-input operation
// ----------------------------------------------------------------------------
`define BGD_LOWIN_ON_NS      19500
`define BGD_LOWIN_ON_CYC     `BGD_CYC_DN(`BGD_LOWIN_ON_NS)
`define BGD_LOWIN_OFF_NS     200
`define BGD_LOWIN_OFF_CYC    `BGD_CYC_UP(`BGD_LOWIN_OFF_NS)
`define BGD_SW_WAIT_NS       70
`define BGD_SW_WAIT_CYC      `BGD_CYC_UP(`BGD_SW_WAIT_NS)
`define BGD_FORCE_NS         100
`define BGD_FORCE_CYC        `BGD_CYC_UP(`BGD_FORCE_NS)

// ----------------------------------------------------------------------------
// Bootstrap pre-charge and burst after pulse-skip
// ----------------------------------------------------------------------------
`define BGD_BOOT_PULSE_NS    250
`define BGD_BOOT_PULSE_CYC   `BGD_CYC_UP(`BGD_BOOT_PULSE_NS)
`define BGD_BOOT_PERIOD_NS   2000
`define BGD_BOOT_PERIOD_CYC  `BGD_CYC_DN(`BGD_BOOT_PERIOD_NS)
`define BGD_BOOT_PULSES      8
`define BGD_BURST_PULSES     3

// ----------------------------------------------------------------------------
// Asynchronous input positions
// ----------------------------------------------------------------------------
`define BGD_IN_SWLOW         0
`define BGD_IN_GLLOW         1
`define BGD_IN_SYNC          2
`define BGD_IN_TRIP          3
`define BGD_IN_LOWIN         4
`define BGD_IN_BELOWREG      5
`define BGD_IN_LIGHT         6
`define BGD_IN_COUNT         7

`endif

// ---- shared/bgd_pkg.sv ----
// Purpose: Types of the buck gate-drive sequencer
// Assumes: Nothing
// Notes:   Constants live in bgd_map.svh
`default_nettype none
package bgd_pkg;
	typedef enum logic [2:0] {
		ST_BOOT = 3'h1,
		ST_RUN  = 3'h2,
		ST_SKIP = 3'h4
	} bgd_state_t;

	// Minimum clamp choice for the error amplifier
	typedef enum logic [1:0] {
		CLAMP_NONE   = 2'h0,
		CLAMP_NORMAL = 2'h1,
		CLAMP_SKIP   = 2'h2,
		CLAMP_BURST  = 2'h3
	} bgd_clamp_t;
endpackage : bgd_pkg
`default_nettype wire

// ---- shared/bgd_sense_if.sv ----
// Purpose: Synchronised comparator and status levels
// Assumes: Driven by bgd_in_sync
// Notes:   All signals are on clk_sys
`default_nettype none
interface bgd_sense_if;
	logic swLow;
	logic glLow;
	logic syncIn;
	logic curTrip;
	logic lowIn;
	logic belowReg;
	logic lightLoad;

	modport prod (output swLow, glLow, syncIn, curTrip, lowIn, belowReg, lightLoad);
	modport cons (input  swLow, glLow, syncIn, curTrip, lowIn, belowReg, lightLoad);
endinterface : bgd_sense_if
`default_nettype wire

// ---- hw/bgd_in_sync.sv ----
// Purpose: Three-stage synchroniser for asynchronous comparator and status pins
// Assumes: Pins may change at any time relative to clk_sys
// Notes:   A level is taken only once stages two and three agree
`default_nettype none
`include "bgd_map.svh"
module bgd_in_sync #(
	parameter int W = `BGD_IN_COUNT
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         resetn,
	// Raw pins
	input  wire logic [W-1:0] rawIn,
	// Clean levels
	bgd_sense_if.prod         sense
);
	logic [W-1:0] meta_r;
	logic [W-1:0] stage2_r;
	logic [W-1:0] stage3_r;
	logic [W-1:0] clean_r;
	logic [W-1:0] clean_nxt;

	// ------------------------------------------------------------------------
	// Agreement filter
	// ------------------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < W; gi++) begin : g_bit
			always_comb begin
				clean_nxt[gi] = (stage2_r[gi] == stage3_r[gi]) ? stage3_r[gi] : clean_r[gi];
			end
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			meta_r   <= '0;
			stage2_r <= '0;
			stage3_r <= '0;
			clean_r  <= '0;
		end else begin
			meta_r   <= rawIn;
			stage2_r <= meta_r;
			stage3_r <= stage2_r;
			clean_r  <= clean_nxt;
		end
	end

	assign sense.swLow     = clean_r[`BGD_IN_SWLOW];
	assign sense.glLow     = clean_r[`BGD_IN_GLLOW];
	assign sense.syncIn    = clean_r[`BGD_IN_SYNC];
	assign sense.curTrip   = clean_r[`BGD_IN_TRIP];
	assign sense.lowIn     = clean_r[`BGD_IN_LOWIN];
	assign sense.belowReg  = clean_r[`BGD_IN_BELOWREG];
	assign sense.lightLoad = clean_r[`BGD_IN_LIGHT];
endmodule : bgd_in_sync
`default_nettype wire

// ---- hw/bgd_gate_seq.sv ----
// Purpose: Gate-drive sequencing for a synchronous buck controller
// Assumes: 200 MHz clk_sys, comparators and status arrive asynchronously
// Notes:   Forced low-side pulses override the switch-node enable
`default_nettype none
`include "bgd_map.svh"
// Contract
// - Except at low input, every switching cycle keeps a minimum high-side off time, limiting duty.
// - At max duty with low input, skip off pulses; oscillator stays 410 kHz.
// - Low input and output below regulation: 19.5 us on, then 200 ns off.
// - After that off edge, set low-side gate once switch node is below 0.4 V.
// - Switch node still high 70 ns after high-side off: force low-side 100 ns.
// - Light load enters pulse-skip; select clamps: skip, burst of 3, none at startup.
// - Startup issues eight 250 ns low-side pulses at 2 us before soft-start ramps.
// - Low-side driver enabled only while switch node reads below 0.4 V; forced, recharge and boot pulses ignore this enable.
// - Sync low, input in range, not skipping: high-side on-time may reach 0 ns.
// - Switch node high 70 ns after sync rise: issue a bootstrap recharge pulse.
// - Recharge pulse ends with sync pulse; sync source must make pulses wide enough.
// - High-side driver enabled only while low-side gate reads below 2 V.
// - Each sync rising edge launches one high-side pulse instead of the oscillator.
module bgd_gate_seq (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	// Asynchronous comparators and status
	input  wire logic       swBelowThr,
	input  wire logic       glBelowThr,
	input  wire logic       syncInput,
	input  wire logic       curLimTrip,
	input  wire logic       lowInput,
	input  wire logic       belowReg,
	input  wire logic       lightLoad,
	// Gate drive
	output logic            highSideGate,
	output logic            lowSideGate,
	// Status
	output logic            softStartRel,
	output logic            skipMode,
	output bgd_pkg::bgd_clamp_t clampSel
);
	import bgd_pkg::*;

	localparam logic [12:0] PERIOD   = 13'(`BGD_PERIOD_CYC);
	localparam logic [12:0] MINOFF   = 13'(`BGD_MIN_OFF_CYC);
	localparam logic [12:0] OFFPT    = 13'(`BGD_PERIOD_CYC - `BGD_MIN_OFF_CYC - 1);
	localparam logic [12:0] REASSERT = 13'(`BGD_REASSERT_PERIODS * `BGD_PERIOD_CYC);
	localparam logic [12:0] LON      = 13'(`BGD_LOWIN_ON_CYC);
	localparam logic [12:0] LOFF     = 13'(`BGD_LOWIN_OFF_CYC);
	localparam logic [12:0] W70      = 13'(`BGD_SW_WAIT_CYC);
	localparam logic [12:0] F100     = 13'(`BGD_FORCE_CYC);
	localparam logic [12:0] BPW      = 13'(`BGD_BOOT_PULSE_CYC);
	localparam logic [12:0] BPER     = 13'(`BGD_BOOT_PERIOD_CYC);
	localparam logic [3:0]  BNUM     = 4'(`BGD_BOOT_PULSES);
	localparam logic [1:0]  BURST    = 2'(`BGD_BURST_PULSES);

	// ------------------------------------------------------------------------
	// Input synchronisation
	// ------------------------------------------------------------------------
	logic [`BGD_IN_COUNT-1:0] rawIn;
	bgd_sense_if sense ();

	assign rawIn[`BGD_IN_SWLOW]    = swBelowThr;
	assign rawIn[`BGD_IN_GLLOW]    = glBelowThr;
	assign rawIn[`BGD_IN_SYNC]     = syncInput;
	assign rawIn[`BGD_IN_TRIP]     = curLimTrip;
	assign rawIn[`BGD_IN_LOWIN]    = lowInput;
	assign rawIn[`BGD_IN_BELOWREG] = belowReg;
	assign rawIn[`BGD_IN_LIGHT]    = lightLoad;

	// Comparators cross four flops before any enable sees them
	bgd_in_sync #(.W(`BGD_IN_COUNT)) uSync (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.rawIn   (rawIn),
		.sense   (sense)
	);

	logic swLowS;
	logic glLowS;
	logic syncS;
	logic tripS;
	logic lowInS;
	logic belowRegS;
	logic lightS;

	assign swLowS    = sense.swLow;
	assign glLowS    = sense.glLow;
	assign syncS     = sense.syncIn;
	assign tripS     = sense.curTrip;
	assign lowInS    = sense.lowIn;
	assign belowRegS = sense.belowReg;
	assign lightS    = sense.lightLoad;

	// ------------------------------------------------------------------------
	// Sequencing state
	// ------------------------------------------------------------------------
	bgd_state_t  state_r,    state_nxt;
	logic [12:0] perCnt_r,   perCnt_nxt;
	logic        syncMode_r, syncMode_nxt;
	logic        syncPrev_r, syncPrev_nxt;
	logic        hsOn_r,     hsOn_nxt;
	logic [12:0] onCnt_r,    onCnt_nxt;
	logic [12:0] offCnt_r,   offCnt_nxt;
	logic        lowOff_r,   lowOff_nxt;
	logic [12:0] forceCnt_r, forceCnt_nxt;
	logic [12:0] syncCnt_r,  syncCnt_nxt;
	logic        syncRech_r, syncRech_nxt;
	logic [12:0] bootCnt_r,  bootCnt_nxt;
	logic [3:0]  bootNum_r,  bootNum_nxt;
	logic [1:0]  burstLeft_r, burstLeft_nxt;
	logic [1:0]  burstDiv_r, burstDiv_nxt;
	logic        ssRel_r,    ssRel_nxt;
	bgd_clamp_t  clamp_r,    clamp_nxt;

	logic syncRise;
	logic cycleStart;
	logic offPoint;
	logic burstGate;
	logic bootPulse;

	always_comb begin
		syncRise   = syncS && !syncPrev_r;
		// The oscillator yields to sync edges until they stop for a while
		cycleStart = syncRise || (!syncMode_r && (perCnt_r >= PERIOD - 13'h1));
		offPoint   = (perCnt_r == OFFPT);
		burstGate  = (burstLeft_r == 2'h0) || (burstDiv_r == 2'h0);
		bootPulse  = (state_r == ST_BOOT) && (bootCnt_r < BPW);

		state_nxt     = state_r;
		perCnt_nxt    = cycleStart ? 13'h0 : ((perCnt_r < REASSERT) ? perCnt_r + 13'h1 : perCnt_r);
		syncMode_nxt  = syncRise ? 1'b1 : ((perCnt_r >= REASSERT) ? 1'b0 : syncMode_r);
		syncPrev_nxt  = syncS;
		hsOn_nxt      = hsOn_r;
		onCnt_nxt     = onCnt_r;
		offCnt_nxt    = hsOn_r ? 13'h0 : ((offCnt_r < LON) ? offCnt_r + 13'h1 : offCnt_r);
		lowOff_nxt    = lowOff_r;
		forceCnt_nxt  = (forceCnt_r != 13'h0) ? forceCnt_r - 13'h1 : 13'h0;
		syncCnt_nxt   = syncCnt_r;
		syncRech_nxt  = syncRech_r && syncS;
		bootCnt_nxt   = bootCnt_r;
		bootNum_nxt   = bootNum_r;
		burstLeft_nxt = burstLeft_r;
		burstDiv_nxt  = burstDiv_r;
		ssRel_nxt     = ssRel_r;

		// Burst after pulse-skip runs at a quarter of the switching rate
		if (cycleStart && (burstLeft_r != 2'h0)) begin
			burstDiv_nxt = burstDiv_r + 2'h1;
		end

		case (state_r)
			ST_BOOT: begin
				// Bootstrap pre-charge holds soft-start until the last pulse
				hsOn_nxt = 1'b0;
				if (bootCnt_r >= BPER - 13'h1) begin
					bootCnt_nxt = 13'h0;
					bootNum_nxt = bootNum_r + 4'h1;
					if (bootNum_r == BNUM - 4'h1) begin
						state_nxt = ST_RUN;
						ssRel_nxt = 1'b1;
					end
				end else begin
					bootCnt_nxt = bootCnt_r + 13'h1;
				end
			end
			ST_RUN: begin
				if (lightS) begin
					state_nxt = ST_SKIP;
					hsOn_nxt  = 1'b0;
					lowOff_nxt = 1'b0;
				end else if (hsOn_r) begin
					onCnt_nxt = onCnt_r + 13'h1;
					if (tripS || syncRech_r) begin
						hsOn_nxt = 1'b0;
					end else if (onCnt_r >= LON - 13'h1) begin
						hsOn_nxt   = 1'b0;
						lowOff_nxt = 1'b1;
					end else if (offPoint && !lowInS) begin
						hsOn_nxt = 1'b0;
					end
					// With low input the off pulse is skipped, period untouched
				end else if (lowOff_r) begin
					if (offCnt_r >= LOFF - 13'h1) begin
						lowOff_nxt = 1'b0;
						if (lowInS && belowRegS && !tripS) begin
							hsOn_nxt  = 1'b1;
							onCnt_nxt = 13'h0;
						end
					end
				end else if (cycleStart && !tripS && burstGate) begin
					// A trip already present at launch gives zero on-time
					hsOn_nxt  = 1'b1;
					onCnt_nxt = 13'h0;
					if (burstLeft_r != 2'h0) begin
						burstLeft_nxt = burstLeft_r - 2'h1;
					end
				end
			end
			ST_SKIP: begin
				hsOn_nxt = 1'b0;
				if (!lightS) begin
					state_nxt     = ST_RUN;
					burstLeft_nxt = BURST;
					burstDiv_nxt  = 2'h0;
				end
			end
			default: begin
				state_nxt = ST_BOOT;
				hsOn_nxt  = 1'b0;
			end
		endcase

		// Switch node slow to fall after a capped on-time: force the low side
		if (lowOff_r && (offCnt_r == W70) && !swLowS) begin
			forceCnt_nxt = F100;
		end

		// Bootstrap recharge 70 ns after a sync rise, while sync stays high
		if (syncRise) begin
			syncCnt_nxt = 13'h1;
		end else if ((syncCnt_r != 13'h0) && (syncCnt_r <= W70)) begin
			syncCnt_nxt = syncCnt_r + 13'h1;
		end
		if ((syncCnt_r == W70) && syncS && !swLowS && (state_r == ST_RUN)) begin
			syncRech_nxt = 1'b1;
		end

		if (state_nxt == ST_BOOT) begin
			clamp_nxt = CLAMP_NONE;
		end else if (state_nxt == ST_SKIP) begin
			clamp_nxt = CLAMP_SKIP;
		end else if (burstLeft_nxt != 2'h0) begin
			clamp_nxt = CLAMP_BURST;
		end else begin
			clamp_nxt = CLAMP_NORMAL;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			state_r     <= ST_BOOT;
			perCnt_r    <= 13'h0;
			syncMode_r  <= 1'b0;
			syncPrev_r  <= 1'b0;
			hsOn_r      <= 1'b0;
			onCnt_r     <= 13'h0;
			offCnt_r    <= 13'h0;
			lowOff_r    <= 1'b0;
			forceCnt_r  <= 13'h0;
			syncCnt_r   <= 13'h0;
			syncRech_r  <= 1'b0;
			bootCnt_r   <= 13'h0;
			bootNum_r   <= 4'h0;
			burstLeft_r <= 2'h0;
			burstDiv_r  <= 2'h0;
			ssRel_r     <= 1'b0;
			clamp_r     <= CLAMP_NONE;
		end else begin
			state_r     <= state_nxt;
			perCnt_r    <= perCnt_nxt;
			syncMode_r  <= syncMode_nxt;
			syncPrev_r  <= syncPrev_nxt;
			hsOn_r      <= hsOn_nxt;
			onCnt_r     <= onCnt_nxt;
			offCnt_r    <= offCnt_nxt;
			lowOff_r    <= lowOff_nxt;
			forceCnt_r  <= forceCnt_nxt;
			syncCnt_r   <= syncCnt_nxt;
			syncRech_r  <= syncRech_nxt;
			bootCnt_r   <= bootCnt_nxt;
			bootNum_r   <= bootNum_nxt;
			burstLeft_r <= burstLeft_nxt;
			burstDiv_r  <= burstDiv_nxt;
			ssRel_r     <= ssRel_nxt;
			clamp_r     <= clamp_nxt;
		end
	end

	// ------------------------------------------------------------------------
	// Gate outputs with non-overlap interlock
	// ------------------------------------------------------------------------
	logic hsGate_r, hsGate_nxt;
	logic lsGate_r, lsGate_nxt;

	always_comb begin
		// Forced pulses ignore the switch-node enable: they exist to pull it down
		lsGate_nxt = (forceCnt_r != 13'h0) || syncRech_r || bootPulse ||
			(!hsOn_r && (state_r != ST_BOOT) && swLowS);
		// Low side must read off before the high side is released
		hsGate_nxt = hsOn_r && glLowS && !lsGate_nxt;
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			hsGate_r <= 1'b0;
			lsGate_r <= 1'b0;
		end else begin
			hsGate_r <= hsGate_nxt;
			lsGate_r <= lsGate_nxt;
		end
	end

	assign highSideGate = hsGate_r;
	assign lowSideGate  = lsGate_r;
	assign softStartRel = ssRel_r;
	assign skipMode     = (state_r == ST_SKIP);
	assign clampSel     = clamp_r;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cbAst @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence seqLsHeld;
		lsGate_r [*8];
	endsequence

	sequence seqForceStart;
		lowOff_r && (offCnt_r == W70) && !swLowS;
	endsequence

	sequence seqSyncLate;
		(syncCnt_r == W70) && syncS && !swLowS && (state_r == ST_RUN);
	endsequence

	chk_min_off: assert property (
		(state_r == ST_RUN) && !lightS && hsOn_r && offPoint && !lowInS |=> !hsOn_r)
		else $error("high side kept on past the minimum off point");

	chk_off_skip: assert property (
		(state_r == ST_RUN) && !lightS && hsOn_r && offPoint && lowInS && !tripS &&
		!syncRech_r && (onCnt_r < LON - 13'h1) |=> hsOn_r)
		else $error("off pulse not skipped under low input");

	chk_on_cap: assert property (
		hsOn_r |-> (onCnt_r < LON))
		else $error("high side on-time beyond low-input cap");

	chk_low_off: assert property (
		$rose(lowOff_r) |-> !hsOn_r ##1 !hsOn_r ##1 !hsOn_r)
		else $error("high side relaunched inside the forced off time");

	chk_force_pulse: assert property (
		seqForceStart |-> ##2 seqLsHeld)
		else $error("forced low-side pulse missing or short");

	chk_clamp_skip: assert property (
		(state_r == ST_SKIP) |-> (clamp_r == CLAMP_SKIP) && !hsOn_r ##1 !hsGate_r)
		else $error("pulse-skip clamp or gate wrong");

	chk_boot_pulse: assert property (
		(state_r == ST_BOOT) && (bootCnt_r == 13'h0) |-> ##1 seqLsHeld)
		else $error("bootstrap pre-charge pulse missing");

	chk_ls_enable: assert property (
		!swLowS && (forceCnt_r == 13'h0) && !syncRech_r && !bootPulse |=> !lsGate_r)
		else $error("low side driven with switch node high");

	chk_sync_rech: assert property (
		seqSyncLate |=> syncRech_r ##1 lsGate_r)
		else $error("bootstrap recharge after sync edge missing");

	chk_rech_end: assert property (
		!syncS |=> !syncRech_r)
		else $error("recharge pulse outlives the sync pulse");

	chk_hs_interlock: assert property (
		hsGate_r |-> $past(glLowS) && !lsGate_r)
		else $error("high side on while low side gate not low");

	chk_sync_launch: assert property (
		syncRise && (state_r == ST_RUN) && !lightS && !hsOn_r && !lowOff_r &&
		!tripS && burstGate |=> hsOn_r)
		else $error("sync edge did not launch a high-side pulse");
endmodule : bgd_gate_seq
`default_nettype wire

// ---- dv/bgd_fet_model.sv ----
// Purpose: Behavioural pair of external power transistors
// Assumes: Gate commands are registered on clk_sys
// Notes:   weakLs models a low side too weak to pull the switch node down
`default_nettype none
module bgd_fet_model (
	// Clock
	input  wire logic clk_sys,
	// Gate commands and fault knob
	input  wire logic highSideGate,
	input  wire logic lowSideGate,
	input  wire logic weakLs,
	// Comparator levels
	output logic      swBelowThr,
	output logic      glBelowThr
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [2:0] lsDly;
	logic [2:0] decay;

	initial begin
		lsDly = 3'h0;
		decay = 3'h0;
		swBelowThr = 1'b1;
	end

	// Switch node falls slowly through the body diode when no gate is on
	always @(posedge clk_sys) begin
		lsDly <= {lsDly[1:0], lowSideGate};
		if (highSideGate || weakLs)
			decay <= 3'h0;
		else if (decay != 3'h7)
			decay <= decay + 3'h1;
		swBelowThr <= !highSideGate && !weakLs && (lowSideGate || decay >= 3'h3);
	end

	// Gate charge makes the low-side level lag its command
	assign glBelowThr = !lsDly[1] && !lowSideGate;
endmodule : bgd_fet_model
`default_nettype wire

// ---- dv/bgd_gate_seq_tb.sv ----
// Purpose: Self-checking bench for the gate-drive sequencer
// Assumes: 200 MHz clock, transistor pair modelled by bgd_fet_model
// Notes:   Pulse widths are noted in queues and checked as pulses end
`default_nettype none
`include "bgd_map.svh"
module bgd_gate_seq_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import bgd_pkg::*;
	typedef struct {int lo; int hi;} bgd_rng_t;
	logic       clk_sys, resetn, swBelowThr, glBelowThr, syncInput, curLimTrip;
	logic       lowInput, belowReg, lightLoad, weakLs;
	logic       highSideGate, lowSideGate, softStartRel, skipMode;
	bgd_clamp_t clampSel;
	int         err_count, comparisons, hsW, hsOff, lsW, hsRises, lastOff, n;
	time        t0;
	bgd_rng_t   hsQ[$], lsQ[$], r;

	bgd_gate_seq uut (.clk_sys(clk_sys), .resetn(resetn), .swBelowThr(swBelowThr),
		.glBelowThr(glBelowThr), .syncInput(syncInput), .curLimTrip(curLimTrip),
		.lowInput(lowInput), .belowReg(belowReg), .lightLoad(lightLoad),
		.highSideGate(highSideGate), .lowSideGate(lowSideGate),
		.softStartRel(softStartRel), .skipMode(skipMode), .clampSel(clampSel));
	bgd_fet_model fets (.clk_sys(clk_sys), .highSideGate(highSideGate),
		.lowSideGate(lowSideGate), .weakLs(weakLs), .swBelowThr(swBelowThr),
		.glBelowThr(glBelowThr));

	initial clk_sys = 1'b0;
	always #2.5 clk_sys = ~clk_sys;

	// ----------------------------------------------------------------------
	// Compare tasks
	// ----------------------------------------------------------------------
	task automatic note(input string m, input logic ok);
		comparisons++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("BAD t=%0t %s", $time, m);
		end
	endtask : note
	task automatic check_clamp(input bgd_clamp_t e);
		note("clamp select", clampSel === e);
	endtask : check_clamp
	task automatic check_rng(input string m, input int v, input int lo, input int hi);
		note(m, v >= lo && v <= hi);
	endtask : check_rng

	task automatic complete_run();
		$display("comparisons=%0d err_count=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask : cyc

	// Bounded wait: 0 soft-start, 1 skip, 2 no skip, 3 clamp normal, 4 hs low, 5 hs high
	task automatic wait_for(input int w, input int limit);
		for (int i = 0; i < limit; i++) begin
			if ((w == 0 && softStartRel === 1'b1) || (w == 1 && skipMode === 1'b1) ||
			    (w == 2 && skipMode === 1'b0) || (w == 3 && clampSel === CLAMP_NORMAL) ||
			    (w == 4 && highSideGate === 1'b0) || (w == 5 && highSideGate === 1'b1))
				return;
			cyc(1);
		end
		note("wait bound", 1'b0);
		complete_run();
	endtask : wait_for

	// Trip ends each pulse 100 cycles after the sync edge
	task automatic sync_pulses(input int k, input int w);
		repeat (k) begin
			syncInput = 1'b1;
			curLimTrip = 1'b0;
			cyc(w);
			syncInput = 1'b0;
			cyc(100 - w);
			curLimTrip = 1'b1;
			cyc(200);
		end
	endtask : sync_pulses

	// ----------------------------------------------------------------------
	// Output watcher
	// ----------------------------------------------------------------------
	always @(posedge clk_sys) begin
		if (resetn === 1'b1 && highSideGate === 1'b1 && lowSideGate === 1'b1)
			note("gates overlap", 1'b0);
		if (highSideGate === 1'b1) begin
			if (hsW == 0) begin
				hsRises++;
				lastOff = hsOff;
			end
			hsW++;
			hsOff = 0;
		end else begin
			if (hsW > 0 && hsQ.size() > 0) begin
				r = hsQ.pop_front();
				check_rng("hs width", hsW, r.lo, r.hi);
			end
			hsW = 0;
			hsOff++;
		end
		if (lowSideGate === 1'b1) begin
			lsW++;
		end else begin
			if (lsW > 0 && lsQ.size() > 0) begin
				r = lsQ.pop_front();
				check_rng("ls width", lsW, r.lo, r.hi);
			end
			lsW = 0;
		end
	end

	// ----------------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------------
	initial begin
		{resetn, syncInput, curLimTrip, lowInput, belowReg, lightLoad, weakLs} = '0;
		{err_count, comparisons, hsW, hsOff, lsW, hsRises, lastOff} = '0;
		void'($urandom(11406));
		cyc(4);
		resetn = 1'b1;
		t0 = $time;
		repeat (`BGD_BOOT_PULSES) lsQ.push_back('{`BGD_BOOT_PULSE_CYC, `BGD_BOOT_PULSE_CYC});
		check_clamp(CLAMP_NONE);
		wait_for(0, 4000);
		check_rng("boot length", int'(($time - t0) / 5), 3150, 3210);
		check_rng("hs in boot", hsRises, 0, 0);
		check_rng("boot pulses left", lsQ.size(), 0, 0);
		$display("boot test done");

		weakLs = 1'b1;
		cyc(3 * `BGD_PERIOD_CYC);
		check_rng("min off", lastOff, `BGD_MIN_OFF_CYC, `BGD_MIN_OFF_CYC + 4);
		cyc($urandom_range(1, `BGD_PERIOD_CYC));
		curLimTrip = 1'b1;
		cyc(20);
		n = hsRises;
		cyc(5 * `BGD_PERIOD_CYC);
		check_rng("pulse under trip", hsRises - n, 0, 0);
		$display("duty test done");

		{curLimTrip, weakLs, lowInput, belowReg} = 4'h3;
		wait_for(5, 5000);
		wait_for(4, 5000);
		lsQ.push_back('{20, 40});
		// Waiting for the low-side gate to read low eats into the gate-level on-time
		hsQ.push_back('{`BGD_LOWIN_ON_CYC - 10, `BGD_LOWIN_ON_CYC + 1});
		wait_for(5, 200);
		weakLs = 1'b1;
		wait_for(4, 5000);
		lsQ.push_back('{`BGD_FORCE_CYC, `BGD_FORCE_CYC + 1});
		wait_for(5, 200);
		cyc(1);
		check_rng("low input off", lastOff, `BGD_LOWIN_OFF_CYC, `BGD_LOWIN_OFF_CYC + 4);
		{lowInput, belowReg} = 2'h0;
		$display("low input test done");

		weakLs = 1'b0;
		curLimTrip = 1'b1;
		wait_for(5, 1000);
		cyc(50);
		n = hsRises;
		sync_pulses(4, 60);
		check_rng("hs per sync edge", hsRises - n, 4, 4);
		weakLs = 1'b1;
		// Let the free-running low-side pulse end before recharge widths are noted
		cyc(20);
		repeat (3) lsQ.push_back('{1, 60 - `BGD_SW_WAIT_CYC});
		sync_pulses(3, 60);
		check_rng("recharge pulses", lsQ.size(), 0, 0);
		$display("sync test done");

		{curLimTrip, weakLs} = 2'h0;
		cyc(4 * `BGD_PERIOD_CYC);
		lightLoad = 1'b1;
		wait_for(1, 20);
		check_clamp(CLAMP_SKIP);
		cyc(10);
		n = hsRises;
		cyc(1500);
		check_rng("hs in skip", hsRises - n, 0, 0);
		lightLoad = 1'b0;
		wait_for(2, 20);
		check_clamp(CLAMP_BURST);
		n = hsRises;
		wait_for(3, 6000);
		cyc(20);
		check_rng("burst launches", hsRises - n, `BGD_BURST_PULSES, `BGD_BURST_PULSES);
		$display("skip test done");
		complete_run();
	end

	initial begin
		#400us;
		note("run limit", 1'b0);
		complete_run();
	end
endmodule : bgd_gate_seq_tb
`default_nettype wire
